// ---- src/xbr_pkg.sv ----
// Purpose: Constants and carriers for the port crossbar peripheral routing block.
// Assumes: Special-function register bus with 8-bit address and data.
// Notes:   Line indices order the routed peripheral signals.
// Overview of operation
// - Bit 6 of control A connects the array count input to a pin.
// - Bits 5:3 of control A route capture outputs 0 up to n-1; 110/111 reserved.
// - Bit 2 of control A: serial A transmit on port A bit 0, receive from bit 1.
// - Bit 1 of control A connects all four sync serial lines, else none.
// - Bit 0 of control A connects both two-wire lines, else none.
// - Bit 6 of control B connects timer C external input to a pin.
// - Bit 5 of control B connects timer C count input to a pin.
// - Bit 4 of control B connects active-low interrupt B input to a pin.
// - Bit 3 of control B connects timer B count input to a pin.
// - Bit 2 of control B connects active-low interrupt A input to a pin.
// - Bit 1 of control B connects timer A count input to a pin.
// - Bit 0 of control B routes comparator B output to a pin.
package xbr_pkg;
  localparam int unsigned DW = 8;
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] ADDR_CTRL_A = 8'he1;
  localparam logic [AW-1:0] ADDR_CTRL_B = 8'he2;
  localparam logic [DW-1:0] RESET_CTRL  = 8'h00;

  // Control A fields
  localparam int unsigned A_CMP_A    = 7;
  localparam int unsigned A_COUNT_IN = 6;
  localparam int unsigned A_CAP_HI   = 5;
  localparam int unsigned A_CAP_LO   = 3;
  localparam int unsigned A_ASYNC    = 2;
  localparam int unsigned A_SYNC     = 1;
  localparam int unsigned A_TWO_WIRE = 0;
  localparam int unsigned CAP_W      = 3;
  localparam logic [CAP_W-1:0] CAP_MAX = 3'h5;

  // Control B fields
  localparam int unsigned B_CLK_OUT = 7;
  localparam int unsigned B_TC_EXT  = 6;
  localparam int unsigned B_TC_CNT  = 5;
  localparam int unsigned B_IRQ_B   = 4;
  localparam int unsigned B_TB_CNT  = 3;
  localparam int unsigned B_IRQ_A   = 2;
  localparam int unsigned B_TA_CNT  = 1;
  localparam int unsigned B_CMP_B   = 0;

  // Routed line indices
  localparam int unsigned L_CMP_A    = 0;
  localparam int unsigned L_COUNT_IN = 1;
  localparam int unsigned L_CAP0     = 2;
  localparam int unsigned N_CAP      = 5;
  localparam int unsigned L_ASYNC_TX = 7;
  localparam int unsigned L_ASYNC_RX = 8;
  localparam int unsigned L_SYNC0    = 9;
  localparam int unsigned N_SYNC     = 4;
  localparam int unsigned L_TW0      = 13;
  localparam int unsigned N_TW       = 2;
  localparam int unsigned L_CLK_OUT  = 15;
  localparam int unsigned L_TC_EXT   = 16;
  localparam int unsigned L_TC_CNT   = 17;
  localparam int unsigned L_IRQ_B    = 18;
  localparam int unsigned L_TB_CNT   = 19;
  localparam int unsigned L_IRQ_A    = 20;
  localparam int unsigned L_TA_CNT   = 21;
  localparam int unsigned L_CMP_B    = 22;
  localparam int unsigned NL         = 23;

  // Level seen by a peripheral whose input line is not routed:
  // sync serial lines (sck, miso, mosi, nss) all idle low, two-wire and irq lines high
  localparam logic [NL-1:0] IDLE_IN = 23'h146000;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic          wr;
    logic          rd;
    logic [DW-1:0] wdata;
  } xbr_sfr_req_s;
endpackage : xbr_pkg

// ---- src/xbr_crossbar.sv ----
// Purpose: Two crossbar routing registers and the per-line pin gating they steer.
// Assumes: Single clock; pin inputs asynchronous; peripherals on clk_sys.
// Notes:   Pin outputs follow a register write by two cycles.
module xbr_crossbar (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire xbr_pkg::xbr_sfr_req_s     sfr_req,
  output logic [xbr_pkg::DW-1:0]         sfr_rdata,
  output logic [xbr_pkg::DW-1:0]         ctrl_a,
  output logic [xbr_pkg::DW-1:0]         ctrl_b,
  output logic [xbr_pkg::NL-1:0]         line_en,
  input  wire logic [xbr_pkg::NL-1:0]    periph_o,
  input  wire logic [xbr_pkg::NL-1:0]    periph_oe,
  output logic [xbr_pkg::NL-1:0]         periph_i,
  input  wire logic [xbr_pkg::NL-1:0]    pin_i,
  output logic [xbr_pkg::NL-1:0]         pin_o,
  output logic [xbr_pkg::NL-1:0]         pin_oe
);
  logic [xbr_pkg::DW-1:0]    ctrl_a_reg;
  logic [xbr_pkg::DW-1:0]    ctrl_b_reg;
  logic [xbr_pkg::DW-1:0]    rdata_reg;
  logic [xbr_pkg::NL-1:0]    en_reg;
  logic [xbr_pkg::NL-1:0]    en_next;
  logic [xbr_pkg::NL-1:0]    sync1_reg;
  logic [xbr_pkg::NL-1:0]    sync2_reg;
  logic [xbr_pkg::NL-1:0]    pin_o_reg;
  logic [xbr_pkg::NL-1:0]    pin_oe_reg;
  logic [xbr_pkg::NL-1:0]    periph_i_reg;
  logic [xbr_pkg::CAP_W-1:0] cap_count;

  // Register writes, full 8 bits stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_a_reg <= xbr_pkg::RESET_CTRL;
      ctrl_b_reg <= xbr_pkg::RESET_CTRL;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == xbr_pkg::ADDR_CTRL_A) begin
        ctrl_a_reg <= sfr_req.wdata;
      end
      if (sfr_req.addr == xbr_pkg::ADDR_CTRL_B) begin
        ctrl_b_reg <= sfr_req.wdata;
      end
    end
  end

  // Read data, unmapped addresses return zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (sfr_req.rd && sfr_req.addr == xbr_pkg::ADDR_CTRL_A) begin
      rdata_reg <= ctrl_a_reg;
    end else if (sfr_req.rd && sfr_req.addr == xbr_pkg::ADDR_CTRL_B) begin
      rdata_reg <= ctrl_b_reg;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign cap_count = ctrl_a_reg[xbr_pkg::A_CAP_HI:xbr_pkg::A_CAP_LO];

  // Decode of each line's enable; no enable depends on another
  always_comb begin
    en_next = '0;
    en_next[xbr_pkg::L_CMP_A]    = ctrl_a_reg[xbr_pkg::A_CMP_A];
    en_next[xbr_pkg::L_COUNT_IN] = ctrl_a_reg[xbr_pkg::A_COUNT_IN];
    for (int k = 0; k < xbr_pkg::N_CAP; k++) begin
      // Reserved codes above the maximum route nothing
      en_next[xbr_pkg::L_CAP0 + k] = (cap_count <= xbr_pkg::CAP_MAX)
                                     && (cap_count > xbr_pkg::CAP_W'(k));
    end
    en_next[xbr_pkg::L_ASYNC_TX] = ctrl_a_reg[xbr_pkg::A_ASYNC];
    en_next[xbr_pkg::L_ASYNC_RX] = ctrl_a_reg[xbr_pkg::A_ASYNC];
    for (int k = 0; k < xbr_pkg::N_SYNC; k++) begin
      en_next[xbr_pkg::L_SYNC0 + k] = ctrl_a_reg[xbr_pkg::A_SYNC];
    end
    for (int k = 0; k < xbr_pkg::N_TW; k++) begin
      en_next[xbr_pkg::L_TW0 + k] = ctrl_a_reg[xbr_pkg::A_TWO_WIRE];
    end
    en_next[xbr_pkg::L_CLK_OUT] = ctrl_b_reg[xbr_pkg::B_CLK_OUT];
    en_next[xbr_pkg::L_TC_EXT]  = ctrl_b_reg[xbr_pkg::B_TC_EXT];
    en_next[xbr_pkg::L_TC_CNT]  = ctrl_b_reg[xbr_pkg::B_TC_CNT];
    en_next[xbr_pkg::L_IRQ_B]   = ctrl_b_reg[xbr_pkg::B_IRQ_B];
    en_next[xbr_pkg::L_TB_CNT]  = ctrl_b_reg[xbr_pkg::B_TB_CNT];
    en_next[xbr_pkg::L_IRQ_A]   = ctrl_b_reg[xbr_pkg::B_IRQ_A];
    en_next[xbr_pkg::L_TA_CNT]  = ctrl_b_reg[xbr_pkg::B_TA_CNT];
    en_next[xbr_pkg::L_CMP_B]   = ctrl_b_reg[xbr_pkg::B_CMP_B];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_reg <= '0;
    end else begin
      en_reg <= en_next;
    end
  end

  // Two-stage synchroniser on every pin input
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Per-line gating; a disabled line never drives its pin nor feeds its peripheral
  genvar g;
  generate
    for (g = 0; g < xbr_pkg::NL; g++) begin : g_line
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          pin_o_reg[g]    <= 1'b0;
          pin_oe_reg[g]   <= 1'b0;
          periph_i_reg[g] <= xbr_pkg::IDLE_IN[g];
        end else begin
          pin_o_reg[g]    <= en_reg[g] & periph_o[g];
          pin_oe_reg[g]   <= en_reg[g] & periph_oe[g];
          periph_i_reg[g] <= en_reg[g] ? sync2_reg[g] : xbr_pkg::IDLE_IN[g];
        end
      end
    end
  endgenerate

  assign sfr_rdata = rdata_reg;
  assign ctrl_a    = ctrl_a_reg;
  assign ctrl_b    = ctrl_b_reg;
  assign line_en   = en_reg;
  assign pin_o     = pin_o_reg;
  assign pin_oe    = pin_oe_reg;
  assign periph_i  = periph_i_reg;
endmodule // xbr_crossbar

// ---- sim/xbr_props.sv ----
// Purpose: Port checks for the crossbar block.
// Assumes: One clock, synchronous reset.
// Notes:   Helper flops keep last-cycle registers.
module xbr_props (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire xbr_pkg::xbr_sfr_req_s sfr_req,
  input wire logic [7:0]            sfr_rdata,
  input wire logic [7:0]            ctrl_a,
  input wire logic [7:0]            ctrl_b,
  input wire logic [22:0]           line_en,
  input wire logic [22:0]           periph_o,
  input wire logic [22:0]           periph_oe,
  input wire logic [22:0]           periph_i,
  input wire logic [22:0]           pin_i,
  input wire logic [22:0]           pin_o,
  input wire logic [22:0]           pin_oe
);
  logic [7:0] pa;
  logic [7:0] pb;
  logic       pr;
  logic [2:0] rst_hist;
  always_ff @(posedge clk_sys) begin
    pa <= ctrl_a;
    pb <= ctrl_b;
    pr <= rst;
    rst_hist <= {rst_hist[1:0], rst};
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  cmp_route_a: assert property (!pr |-> line_en[0] == pa[7] && line_en[22] == pb[0])
    else $error("comparator routing wrong");
  count_in_route_a: assert property (!pr |-> line_en[1] == pa[6])
    else $error("count input routing wrong");
  capture_count_a: assert property (!pr |-> line_en[6:2] ==
    ((pa[5:3] > 3'h5) ? 5'h0 : 5'h1f >> (3'h5 - pa[5:3]))) else $error("capture routing wrong");
  async_route_a: assert property (!pr |-> line_en[8:7] == {2{pa[2]}})
    else $error("serial routing wrong");
  sync_route_a: assert property (!pr |-> line_en[12:9] == {4{pa[1]}})
    else $error("sync serial routing wrong");
  two_wire_a: assert property (!pr |-> line_en[14:13] == {2{pa[0]}})
    else $error("two-wire routing wrong");
  ctrl_b_route_a: assert property (!pr |-> line_en[21:15] ==
    {pb[1], pb[2], pb[3], pb[4], pb[5], pb[6], pb[7]}) else $error("control b routing wrong");
  pin_gate_a: assert property (!pr |-> pin_oe == ($past(line_en) & $past(periph_oe))
    && pin_o == ($past(line_en) & $past(periph_o))) else $error("pin gating wrong");
  write_back_a: assert property (sfr_req.wr |=> ctrl_a ==
    ($past(sfr_req.addr) == 8'he1 ? $past(sfr_req.wdata) : $past(ctrl_a))) else $error("ctrl a write");
  // Pin level reaches its peripheral three edges late: two sync stages plus the gate
  periph_in_a: assert property (rst_hist == 3'h0 |-> periph_i ==
    (($past(line_en) & $past(pin_i, 3)) | (~$past(line_en) & xbr_pkg::IDLE_IN)))
    else $error("peripheral input routing wrong");
  cover property (sfr_req.wr && sfr_req.addr == 8'he2);
  cover property (line_en[6:2] == 5'h1f);
  cover property (pin_oe != 23'h0);
endmodule // xbr_props
bind xbr_crossbar xbr_props u_props (.clk_sys(clk_sys), .rst(rst), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .line_en(line_en),
  .periph_o(periph_o), .periph_oe(periph_oe), .periph_i(periph_i), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe(pin_oe));

// ---- sim/xbr_far.sv ----
// Purpose: Pins and peripherals around the crossbar.
// Assumes: Levels change every cycle.
// Notes:   Input-only lines are never driven.
module xbr_far (
  input wire logic    clk_sys,
  output logic [22:0] periph_o,
  output logic [22:0] periph_oe,
  output logic [22:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 32'h5a5a;
  initial begin
    periph_o = 23'h0;
    periph_oe = 23'h0;
    pin_i = 23'h0;
    forever begin
      @(posedge clk_sys);
      #1;
      periph_o = 23'($random(seed));
      periph_oe = 23'($random(seed)) & 23'h40fefd;
      pin_i = 23'($random(seed));
    end
  end
endmodule // xbr_far

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the crossbar.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Random register pairs plus all capture codes.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  xbr_pkg::xbr_sfr_req_s sfr_req = '0;
  logic [7:0]            sfr_rdata, ctrl_a, ctrl_b, q;
  logic [22:0]           line_en, periph_o, periph_oe, periph_i, pin_i, pin_o, pin_oe;
  int                    errors = 0, total_checks = 0, cyc = 0, seed = 32'hf66f;
  always #5 clk_sys = ~clk_sys;
  xbr_crossbar u_dut (.clk_sys(clk_sys), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .line_en(line_en), .periph_o(periph_o),
    .periph_oe(periph_oe), .periph_i(periph_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
  xbr_far u_far (.clk_sys(clk_sys), .periph_o(periph_o), .periph_oe(periph_oe), .pin_i(pin_i));
  function automatic logic [22:0] exp_en(input logic [7:0] a, input logic [7:0] b);
    logic [4:0] cm;
    cm = (a[5:3] > 3'h5) ? 5'h0 : 5'h1f >> (3'h5 - a[5:3]);
    return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7], {2{a[0]}}, {4{a[1]}}, {2{a[2]}},
      cm, a[6], a[7]};
  endfunction
  task automatic chk(input string n, input logic [22:0] got, input logic [22:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_req = '{addr: ad, wr: w, rd: !w, wdata: d};
    @(posedge clk_sys);
    #1;
    q = sfr_rdata;
    sfr_req.wr = 1'b0;
    sfr_req.rd = 1'b0;
  endtask
  task automatic route(input logic [7:0] a, input logic [7:0] b);
    bus(1'b1, 8'he1, a);
    bus(1'b1, 8'he2, b);
    bus(1'b0, 8'he1, 8'h0);
    chk("ctrl_a", 23'(q), 23'(a));
    bus(1'b0, 8'he2, 8'h0);
    chk("ctrl_b", 23'(q), 23'(b));
    chk("line_en", line_en, exp_en(a, b));
    chk("idle", periph_i & ~line_en, xbr_pkg::IDLE_IN & ~line_en);
  endtask
  task automatic close_out;
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
    bus(1'b0, 8'he2, 8'h0);
    chk("reset b", 23'(q), 23'h0);
    chk("reset idle", periph_i, xbr_pkg::IDLE_IN);
    for (int i = 0; i < 8; i++) route(8'(i << 3), 8'(1 << i));
    route(8'hff, 8'hff);
    route(8'h00, 8'h00);
    repeat (40) route(8'($random(seed)), 8'($random(seed)));
    bus(1'b1, 8'he3, 8'hff);
    bus(1'b0, 8'he3, 8'h0);
    chk("unmapped", 23'(q), 23'h0);
    close_out();
  end
endmodule // tb_top
